// ---- include/bmps_pkg.sv ----
// Constants, mode encoding and state layout of the burst/protection sequencer
package bmps_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned ENTRY_BLANK_MS  = 24;
    localparam int unsigned OL_BLANK_MS     = 30;
    localparam int unsigned ENTRY_BLANK_CYC = CLK_HZ / 1000 * ENTRY_BLANK_MS;
    localparam int unsigned OL_BLANK_CYC    = CLK_HZ / 1000 * OL_BLANK_MS;
    localparam int unsigned BURST_FREQ_HZ   = 52_000;
    localparam int unsigned BURST_PERIOD_CYC = CLK_HZ / BURST_FREQ_HZ;
    localparam int unsigned BURST_DUTY_PCT  = 50;
    localparam int unsigned BURST_ON_CYC    =
        BURST_PERIOD_CYC * BURST_DUTY_PCT / 100;
    localparam int unsigned MAX_ON_NS       = 30_000;
    localparam int unsigned MAX_ON_CYC      =
        MAX_ON_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int unsigned OVP_BLANK_NS    = 1_000;
    localparam int unsigned OVP_BLANK_CYC   =
        OVP_BLANK_NS * (CLK_HZ / 1_000_000) / 1000;
    // Counter widths
    localparam int unsigned LONG_W  = 20;
    localparam int unsigned SHORT_W = 10;
    localparam int unsigned ZC_W    = 8;
    // Synchronised comparator vector positions
    localparam int unsigned IX_FB_ENTRY  = 0;
    localparam int unsigned IX_FB_RESUME = 1;
    localparam int unsigned IX_FB_IDLE   = 2;
    localparam int unsigned IX_FB_EXIT   = 3;
    localparam int unsigned IX_FB_HIGH   = 4;
    localparam int unsigned IX_CS_PWM    = 5;
    localparam int unsigned IX_CS_BURST  = 6;
    localparam int unsigned IX_CS_SHORT  = 7;
    localparam int unsigned IX_ZC_OVP    = 8;
    localparam int unsigned IX_VALLEY    = 9;
    localparam int unsigned IX_CNT_TOP   = 10;
    localparam int unsigned IX_VCC_UV    = 11;
    localparam int unsigned IX_VCC_OV    = 12;
    localparam int unsigned IX_VCC_ON    = 13;
    localparam int unsigned IX_VCC_OFF   = 14;
    localparam int unsigned IX_VCC_PD    = 15;
    localparam int unsigned IX_OVER_TEMP = 16;
    localparam int unsigned NPIN         = 17;
    // Foldback curve (codes of the digitised zero-crossing current)
    localparam logic [ZC_W-1:0] FOLD_FIRST_STEP = 8'h20;
    localparam logic [ZC_W-1:0] CS_LIMIT_FULL   = 8'hFF;
    localparam logic [ZC_W-1:0] CS_LIMIT_MIN    = 8'hA3;
    localparam logic [4:0]      FOLD_KNEE       = 5'h04;
    localparam int unsigned     FOLD_STEP_LSB   = 3;
    // Operating modes
    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_RUN   = 2'b01,
        MODE_AUTO  = 2'b10,
        MODE_LATCH = 2'b11
    } bmps_mode_t;
    // Whole block state
    typedef struct packed {
        logic [NPIN-1:0]    sync1;
        logic [NPIN-1:0]    sync2;
        logic [ZC_W-1:0]    zc1;
        logic [ZC_W-1:0]    zc2;
        bmps_mode_t         st;
        logic               burst;
        logic               bias;
        logic               gate;
        logic               charge;
        logic               ss;
        logic               force_min;
        logic [ZC_W-1:0]    limit;
        logic [LONG_W-1:0]  ent_cnt;
        logic [LONG_W-1:0]  ol_cnt;
        logic [SHORT_W-1:0] ovp_cnt;
        logic [SHORT_W-1:0] on_cnt;
        logic [SHORT_W-1:0] bt_cnt;
        logic               in_auto;
        logic               in_latch;
    } bmps_state_t;
endpackage

// ---- hw/bmps_sequencer.sv ----
// Burst mode, protection and foldback sequencer of a flyback controller
module bmps_sequencer #(
    parameter int unsigned ENTRY_CYC = bmps_pkg::ENTRY_BLANK_CYC,
    parameter int unsigned OL_CYC    = bmps_pkg::OL_BLANK_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Feedback comparators
    input  wire logic fb_below_entry,
    input  wire logic fb_above_resume,
    input  wire logic fb_below_idle,
    input  wire logic fb_above_exit,
    input  wire logic fb_pulled_high,
    // Current sense comparators
    input  wire logic cs_pwm_trip,
    input  wire logic cs_above_burst_peak,
    input  wire logic cs_above_short_winding,
    // Zero-crossing pin
    input  wire logic zc_above_overvoltage,
    input  wire logic valley_turn_on,
    input  wire logic [bmps_pkg::ZC_W-1:0] zc_current,
    input  wire logic updown_at_top,
    // Supply and temperature monitors
    input  wire logic supply_under,
    input  wire logic supply_over,
    input  wire logic supply_above_on,
    input  wire logic supply_below_off,
    input  wire logic supply_below_pd,
    input  wire logic over_temp,
    // Gate and status
    output logic      gate_drive,
    output logic      burst_active,
    output logic      bias_active,
    output logic      counter_force_min,
    output logic      soft_start,
    output logic      startup_charge,
    output logic      auto_restart,
    output logic      latched_off,
    output logic [bmps_pkg::ZC_W-1:0] cs_limit_code
);
    import bmps_pkg::*;

    // Counters must fit their fields and run at least two cycles
    if (ENTRY_CYC < 2 || ENTRY_CYC >= (1 << LONG_W) ||
        OL_CYC < 2 || OL_CYC >= (1 << LONG_W)) begin : g_bad_count
        $error("bmps_sequencer: blanking count out of range");
    end

    bmps_state_t     q;
    bmps_state_t     d;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s;
    logic            max_on_hit;
    logic            ent_cond;
    logic            ent_hit;
    logic            ol_cond;
    logic            ol_hit;
    logic            ovp_cond;
    logic            ovp_hit;
    logic            latch_hit;
    logic            auto_hit;

    // Gather raw comparator pins in package order
    assign pin_raw = {over_temp, supply_below_pd, supply_below_off,
                      supply_above_on, supply_over, supply_under,
                      updown_at_top, valley_turn_on, zc_above_overvoltage,
                      cs_above_short_winding, cs_above_burst_peak,
                      cs_pwm_trip, fb_pulled_high, fb_above_exit,
                      fb_below_idle, fb_above_resume, fb_below_entry};
    assign s = q.sync2;

    // Stepped foldback: steep slope up to the knee, shallower beyond
    function automatic logic [ZC_W-1:0] fold_limit(
        input logic [ZC_W-1:0] cur
    );
        logic [ZC_W-1:0] excess;
        logic [4:0]      step;
        logic [ZC_W:0]   red;
        logic [ZC_W:0]   lim;
        excess = 8'h00;
        step   = 5'h00;
        red    = 9'h000;
        lim    = {1'b0, CS_LIMIT_FULL};
        if (cur > FOLD_FIRST_STEP) begin
            excess = cur - FOLD_FIRST_STEP;
            step   = excess[ZC_W-1:FOLD_STEP_LSB];
            if (step <= FOLD_KNEE)
                red = {2'b00, step, 2'b00};
            else
                red = {2'b00, FOLD_KNEE, 2'b00}
                    + {3'b000, step - FOLD_KNEE, 1'b0};
            lim = {1'b0, CS_LIMIT_FULL} - red;
        end
        if (lim < {1'b0, CS_LIMIT_MIN})
            lim = {1'b0, CS_LIMIT_MIN};
        return lim[ZC_W-1:0];
    endfunction

    // Qualifying conditions and blanking timer expiries
    always_comb begin
        max_on_hit = q.gate && (q.on_cnt == SHORT_W'(MAX_ON_CYC - 1));
        ent_cond   = !q.burst && s[IX_FB_ENTRY] && s[IX_CNT_TOP];
        ent_hit    = ent_cond && (q.ent_cnt == LONG_W'(ENTRY_CYC - 1));
        ol_cond    = !q.burst && s[IX_FB_HIGH];
        ol_hit     = ol_cond && (q.ol_cnt == LONG_W'(OL_CYC - 1));
        ovp_cond   = !q.gate && s[IX_ZC_OVP];
        ovp_hit    = ovp_cond && (q.ovp_cnt == SHORT_W'(OVP_BLANK_CYC - 1));
        latch_hit  = ovp_hit ||
                     (q.gate && !q.burst && s[IX_CS_SHORT]);
        auto_hit   = s[IX_VCC_UV] || s[IX_VCC_OV] || ol_hit ||
                     (!q.burst && s[IX_OVER_TEMP]);
    end

    // Next state
    always_comb begin
        d           = q;
        d.sync1     = pin_raw;
        d.sync2     = q.sync1;
        d.zc1       = zc_current;
        d.zc2       = q.zc1;
        d.ss        = 1'b0;
        d.force_min = 1'b0;
        // foldback sense limit
        // Only a code seen twice is used, so bit skew never glitches it
        if (q.zc1 == q.zc2)
            d.limit = fold_limit(q.zc2);
        unique case (q.st)
            MODE_OFF: begin
                d.charge = 1'b1;
                if (s[IX_VCC_ON]) begin
                    d.st        = MODE_RUN;
                    d.charge    = 1'b0;
                    d.bias      = 1'b1;
                    d.ss        = 1'b1;
                    d.force_min = 1'b1;
                end
            end
            MODE_AUTO: begin
                if (s[IX_VCC_OFF]) begin
                    d.charge = 1'b1;
                end else if (s[IX_VCC_ON] && q.charge) begin
                    d.st        = MODE_RUN;
                    d.charge    = 1'b0;
                    d.bias      = 1'b1;
                    d.ss        = 1'b1;
                    d.force_min = 1'b1;
                end
            end
            MODE_LATCH: begin
                if (s[IX_VCC_OFF])
                    d.charge = 1'b1;
                else if (s[IX_VCC_ON])
                    d.charge = 1'b0;
                if (s[IX_VCC_PD]) begin
                    d.st     = MODE_OFF;
                    d.charge = 1'b1;
                end
            end
            MODE_RUN: begin
                d.on_cnt = q.gate ? q.on_cnt + 1'b1 : '0;
                if (q.burst && q.bt_cnt != SHORT_W'(BURST_PERIOD_CYC - 1))
                    d.bt_cnt = q.bt_cnt + 1'b1;
                else
                    d.bt_cnt = '0;
                if (!q.burst) begin
                    // Valley logic launches, sense trip ends the pulse
                    if (!q.gate && s[IX_VALLEY])
                        d.gate = 1'b1;
                    if (q.gate && s[IX_CS_PWM])
                        d.gate = 1'b0;
                end else begin
                    if (q.bias && !q.gate && q.bt_cnt == '0)
                        d.gate = 1'b1;
                    // peak level or duty, first wins
                    if (q.gate && (s[IX_CS_BURST] ||
                        q.on_cnt == SHORT_W'(BURST_ON_CYC - 1)))
                        d.gate = 1'b0;
                    if (!q.bias && s[IX_FB_RESUME])
                        d.bias = 1'b1;
                    if (q.bias && s[IX_FB_IDLE]) begin
                        d.bias = 1'b0;
                        d.gate = 1'b0;
                    end
                end
                if (max_on_hit)
                    d.gate = 1'b0;
                d.ent_cnt = ent_cond ? q.ent_cnt + 1'b1 : '0;
                if (ent_hit) begin
                    d.burst   = 1'b1;
                    d.bias    = 1'b0;
                    d.gate    = 1'b0;
                    d.ent_cnt = '0;
                end
                if (q.burst && s[IX_FB_EXIT]) begin
                    d.burst     = 1'b0;
                    d.bias      = 1'b1;
                    d.bt_cnt    = '0;
                    d.force_min = 1'b1;
                end
                d.ol_cnt  = (ol_cond && !ent_hit) ? q.ol_cnt + 1'b1 : '0;
                d.ovp_cnt = ovp_cond ? q.ovp_cnt + 1'b1 : '0;
                if (latch_hit || auto_hit) begin
                    d.st      = latch_hit ? MODE_LATCH : MODE_AUTO;
                    d.gate    = 1'b0;
                    d.burst   = 1'b0;
                    d.bias    = 1'b0;
                    d.charge  = 1'b0;
                    d.ent_cnt = '0;
                    d.ol_cnt  = '0;
                    d.ovp_cnt = '0;
                    d.on_cnt  = '0;
                    d.bt_cnt  = '0;
                end
            end
        endcase
        // Mode flags kept in flops so the mode outputs come straight off them
        d.in_auto  = (d.st == MODE_AUTO);
        d.in_latch = (d.st == MODE_LATCH);
    end

    // State register; everything starts off with the switch open
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs taken straight from state flops
    assign gate_drive        = q.gate;
    assign burst_active      = q.burst;
    assign bias_active       = q.bias;
    assign counter_force_min = q.force_min;
    assign soft_start        = q.ss;
    assign startup_charge    = q.charge;
    assign auto_restart      = q.in_auto;
    assign latched_off       = q.in_latch;
    assign cs_limit_code     = q.limit;

    // Checks on the sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence burst_leave_s;
        q.burst && q.st == MODE_RUN ##1 !q.burst && q.st == MODE_RUN;
    endsequence

    sequence ovp_expire_s;
        q.st == MODE_RUN && ovp_cond &&
        q.ovp_cnt == SHORT_W'(OVP_BLANK_CYC - 1);
    endsequence

    entry_blank_a: assert property ($rose(q.burst) |->
        $past(q.ent_cnt) == LONG_W'(ENTRY_CYC - 1))
        else $error("burst entered before entry blanking");
    burst_resume_a: assert property (q.st == MODE_RUN && q.burst &&
        !q.bias && s[IX_FB_RESUME] && !s[IX_FB_EXIT] && !auto_hit &&
        !latch_hit |=> q.bias)
        else $error("burst bias not resumed");
    burst_launch_a: assert property ($rose(q.gate) && q.burst |->
        $past(q.bt_cnt) == '0)
        else $error("burst pulse not launched by timer");
    burst_duty_a: assert property (q.gate && q.burst |->
        q.on_cnt < SHORT_W'(BURST_ON_CYC))
        else $error("burst pulse exceeded duty limit");
    burst_idle_a: assert property (q.st == MODE_RUN && q.burst &&
        q.bias && s[IX_FB_IDLE] && !s[IX_FB_EXIT] |=> !q.gate)
        else $error("burst switching not stopped at idle level");
    exit_force_a: assert property (burst_leave_s |-> q.force_min)
        else $error("counter not forced on burst exit");
    ol_mask_a: assert property (q.burst |-> q.ol_cnt == '0)
        else $error("overload timer ran in burst");
    ovp_latch_a: assert property (ovp_expire_s |=>
        q.st == MODE_LATCH && !q.gate)
        else $error("output over-voltage did not latch off");
    latch_hold_a: assert property (q.st == MODE_LATCH &&
        !s[IX_VCC_PD] |=> q.st == MODE_LATCH)
        else $error("latch released without power-down");
    max_on_a: assert property (q.gate |->
        q.on_cnt < SHORT_W'(MAX_ON_CYC))
        else $error("gate high past maximum on-time");
endmodule

// ---- testbench/bmps_stage_model.sv ----
// Power stage model: sense ramp, valley ringing and auxiliary winding
module bmps_stage_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Gate and scenario knobs
    input  wire logic       gate_drive,
    input  wire logic [9:0] trip_cyc,
    input  wire logic       valley_en,
    input  wire logic       ovp_req,
    // Comparator results towards the block
    output logic            cs_pwm_trip,
    output logic            cs_above_burst_peak,
    output logic            valley_turn_on,
    output logic            zc_above_overvoltage
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] on_q;
    logic [9:0] off_q;
    // Ramp counters; the off count saturates so valleys never vanish
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on_q  <= 10'h000;
            off_q <= 10'h000;
        end else begin
            on_q  <= gate_drive ? on_q + 10'h001 : 10'h000;
            off_q <= gate_drive ? 10'h000 : off_q + 10'(off_q != 10'h3FF);
        end
    end
    // A zero trip count models a sense ramp too slow to ever trip
    always_comb begin
        cs_pwm_trip = gate_drive && trip_cyc != 10'h000 && on_q >= trip_cyc;
        cs_above_burst_peak = cs_pwm_trip;
        valley_turn_on = valley_en && !gate_drive && off_q >= 10'h014;
        // Aux winding shows output level only while the switch is off
        zc_above_overvoltage = ovp_req && !gate_drive;
    end
endmodule

// ---- testbench/bmps_sequencer_tb.sv ----
// Self-checking bench of the burst and protection sequencer
module bmps_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import bmps_pkg::*;
    localparam int ENT = 20;
    localparam int OLC = 30;
    logic clk = 0, rstn = 0, valley_en = 0, ovp_req = 0;
    logic fb_below_entry = 0, fb_above_resume = 0, fb_below_idle = 0;
    logic fb_above_exit = 0, fb_pulled_high = 0, cs_above_short_winding = 0;
    logic updown_at_top = 0, supply_under = 0, supply_over = 0;
    logic supply_above_on = 0, supply_below_off = 0, supply_below_pd = 0;
    logic over_temp = 0;
    logic [7:0] zc_current = 8'h00;
    logic [9:0] trip_cyc = 10'h000;
    logic cs_pwm_trip, cs_above_burst_peak, valley_turn_on;
    logic zc_above_overvoltage, gate_drive, burst_active, bias_active;
    logic counter_force_min, soft_start, startup_charge, auto_restart;
    logic latched_off;
    logic [7:0] cs_limit_code;
    int mismatches = 0, comparisons = 0;
    int ss_n = 0, cf_n = 0, hi_n = 0, last_hi = 0, per_n = 0;
    int last_per = 0, rise_n = 0;
    bit g_d = 0;

    bmps_sequencer #(.ENTRY_CYC(ENT), .OL_CYC(OLC)) bmps_sequencer_i (.*);
    bmps_stage_model bmps_stage_model_i (.*);

    // Clock of 40 ns
    always #20 clk = ~clk;

    // Pulse counters and gate run lengths, sampled before each edge lands
    always @(posedge clk) begin
        if (soft_start === 1'b1) ss_n++;
        if (counter_force_min === 1'b1) cf_n++;
        per_n++;
        if (gate_drive === 1'b1) begin
            if (!g_d) begin
                last_per = per_n;
                per_n = 0;
                rise_n++;
            end
            hi_n++;
        end else begin
            if (hi_n != 0) last_hi = hi_n;
            hi_n = 0;
        end
        g_d = (gate_drive === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen,
                     exp);
        end
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Expected sense limit: 4 codes a step up to the knee, then 2
    function automatic logic [7:0] fold(input logic [7:0] z);
        int s;
        int r;
        if (z < FOLD_FIRST_STEP) return CS_LIMIT_FULL;
        s = (int'(z) - int'(FOLD_FIRST_STEP)) >> FOLD_STEP_LSB;
        r = (s <= 4) ? 4 * s : 16 + 2 * (s - 4);
        if (255 - r < int'(CS_LIMIT_MIN)) return CS_LIMIT_MIN;
        return 8'(255 - r);
    endfunction

    // start from supply turn-on with a fresh soft-start
    task automatic t_start();
        int s0;
        s0 = ss_n;
        check(startup_charge, 1);
        supply_above_on = 1;
        tick(5);
        supply_above_on = 0;
        check(ss_n - s0, 1);
        check(bias_active, 1);
        check(startup_charge, 0);
    endtask

    // recharge and restart out of auto-restart
    task automatic t_restart();
        supply_below_off = 1;
        tick(5);
        check(startup_charge, 1);
        supply_below_off = 0;
        t_start();
        check(auto_restart, 0);
    endtask

    // gate cut at maximum on-time when sense never trips
    task automatic t_max_on();
        valley_en = 1;
        trip_cyc = 10'h000;
        tick(820);
        check(last_hi, MAX_ON_CYC);
        trip_cyc = 10'h01E;
    endtask

    // stepped foldback over a table of currents
    task automatic t_fold();
        logic [7:0] tbl [9] = '{8'h00, 8'h1F, 8'h20, 8'h27, 8'h28, 8'h40,
                               8'h48, 8'h60, 8'hFF};
        foreach (tbl[i]) begin
            zc_current = tbl[i];
            tick(6);
            check(cs_limit_code, fold(tbl[i]));
        end
    endtask

    // overload after full blanking, then other auto faults
    task automatic t_faults();
        fb_pulled_high = 1;
        tick(OLC - 5);
        fb_pulled_high = 0;
        tick(2);
        check(auto_restart, 0);
        fb_pulled_high = 1;
        tick(OLC + 5);
        check(auto_restart, 1);
        check(gate_drive, 0);
        fb_pulled_high = 0;
        t_restart();
        for (int i = 0; i < 3; i++) begin
            tick(100);
            {supply_under, supply_over, over_temp} = 3'b100 >> i;
            tick(5);
            check(auto_restart, 1);
            check(latched_off, 0);
            check(gate_drive, 0);
            {supply_under, supply_over, over_temp} = 3'b000;
            t_restart();
        end
    endtask

    // burst entry, pulses, masking, idle and exit
    task automatic t_burst();
        int c0;
        int r0;
        valley_en = 0;
        fb_below_entry = 1;
        updown_at_top = 1;
        tick(ENT - 5);
        updown_at_top = 0;
        tick(4);
        updown_at_top = 1;
        tick(ENT - 2);
        check(burst_active, 0);
        tick(8);
        check(burst_active, 1);
        check(bias_active, 0);
        {fb_below_entry, updown_at_top} = 2'b00;
        trip_cyc = 10'h000;
        fb_above_resume = 1;
        tick(4);
        fb_above_resume = 0;
        check(bias_active, 1);
        {fb_pulled_high, over_temp, cs_above_short_winding} = 3'b111;
        tick(1100);
        check(last_per, BURST_PERIOD_CYC);
        check(last_hi, BURST_ON_CYC);
        check({auto_restart, latched_off}, 2'b00);
        {fb_pulled_high, over_temp, cs_above_short_winding} = 3'b000;
        trip_cyc = 10'h00A;
        tick(1000);
        // Sense trips after 10 cycles high, three more cycles to act
        check(last_hi, 13);
        fb_below_idle = 1;
        tick(4);
        fb_below_idle = 0;
        tick(300);
        r0 = rise_n;
        tick(1000);
        check(rise_n - r0, 0);
        check(bias_active, 0);
        c0 = cf_n;
        fb_above_exit = 1;
        tick(5);
        fb_above_exit = 0;
        check(burst_active, 0);
        check(bias_active, 1);
        check(cf_n - c0, 1);
    endtask

    // latch on output over-voltage, short winding, release
    task automatic t_latch();
        ovp_req = 1;
        tick(60);
        ovp_req = 0;
        check(latched_off, 1);
        supply_below_off = 1;
        tick(5);
        check(startup_charge, 1);
        supply_below_off = 0;
        supply_above_on = 1;
        tick(5);
        supply_above_on = 0;
        check(startup_charge, 0);
        supply_under = 1;
        tick(5);
        supply_under = 0;
        check({latched_off, gate_drive}, 2'b10);
        supply_below_pd = 1;
        tick(5);
        supply_below_pd = 0;
        check(latched_off, 0);
        t_start();
        valley_en = 1;
        trip_cyc = 10'h000;
        for (int k = 0; k < 100 && gate_drive !== 1'b1; k++) tick(1);
        cs_above_short_winding = 1;
        tick(5);
        cs_above_short_winding = 0;
        check({latched_off, gate_drive}, 2'b10);
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        #(20000 * 40);
        mismatches++;
        results();
    end

    initial begin
        tick(8);
        rstn = 1;
        tick(1);
        t_start();
        t_max_on();
        t_fold();
        t_faults();
        t_burst();
        t_latch();
        results();
    end
endmodule
